// >>> hw/twc_pkg.sv
/*
 * Shared constants and types for the two-wire controller clock generator
 * and transfer status block.
 * Assumes byte addresses on the register port and a 32-bit data path.
 */
package twc_pkg;

  // Register byte addresses.
  localparam logic [31:0] ADDR_INTERNAL_ADDRESS = 32'h4001800c;
  localparam logic [31:0] ADDR_CLOCK_WAVEFORM   = 32'h40018010;
  localparam logic [31:0] ADDR_TRANSFER_STATUS  = 32'h40018020;

  // Reset values.
  localparam logic [23:0] RESET_INTERNAL_ADDRESS = 24'h000000;
  localparam logic [31:0] RESET_CLOCK_WAVEFORM   = 32'h00000000;

  // Clock waveform fields.
  localparam int CW_LOW_POS  = 0;
  localparam int CW_HIGH_POS = 8;
  localparam int CW_EXP_POS  = 16;
  localparam int CW_HOLD_POS = 24;
  localparam logic [31:0] CW_WRITE_MASK = 32'h3f07ffff;

  // Fixed part added to every programmed period.
  localparam logic [15:0] PERIOD_OFFSET = 16'h0003;
  localparam logic [6:0]  HOLD_OFFSET   = 7'h03;

  // Transfer status bit positions.
  localparam int SR_TRANSFER_COMPLETE = 0;
  localparam int SR_RECEIVE_READY     = 1;
  localparam int SR_TRANSMIT_READY    = 2;
  localparam int SR_SLAVE_DIRECTION   = 3;
  localparam int SR_SLAVE_ACCESS      = 4;
  localparam int SR_GENERAL_CALL      = 5;
  localparam int SR_OVERRUN           = 6;
  localparam int SR_UNDERRUN          = 7;
  localparam int SR_NACK              = 8;
  localparam int SR_ARBITRATION_LOST  = 9;
  localparam int SR_CLOCK_WAIT        = 10;
  localparam int SR_END_SLAVE_ACCESS  = 11;
  localparam int SR_END_RX_BUFFER     = 12;
  localparam int SR_END_TX_BUFFER     = 13;
  localparam int SR_CLOCK_LINE        = 24;
  localparam int SR_DATA_LINE         = 25;

  // Reset state of the flags that are not cleared on read.
  localparam logic RESET_TRANSFER_COMPLETE = 1'b1;
  localparam logic RESET_TRANSMIT_READY    = 1'b0;

  typedef enum logic [1:0] {CG_IDLE, CG_LOW, CG_HIGH} twc_clk_state_type;

  // Events from the shifters, bus monitor and transfer counters.
  typedef struct packed {
    logic thr_write;
    logic rhr_read;
    logic byte_to_shifter;
    logic rx_byte_loaded;
    logic shifter_empty;
    logic stop_sent;
    logic start_seen;
    logic stop_seen;
    logic restart_other_addr;
    logic addr_match;
    logic addr_read_bit;
    logic nack_seen;
    logic general_call;
    logic arb_lost;
    logic next_char_due;
    logic tx_byte_acked;
    logic rx_count_zero;
    logic tx_count_zero;
    logic rx_count_write;
    logic tx_count_write;
  } twc_event_type;

endpackage

// >>> hw/twc_clkgen_status.sv
/*
 * Master clock waveform generator, data hold timing, internal address
 * register and transfer status flags of the two-wire controller.
 * Assumes the shifters, control and mode registers sit outside and report
 * through the event bundle; all inputs are synchronous to clock_i.
 */
// Notes on behaviour
// - Internal address register supplies zero to three bytes chosen by the size field.
// - Master clock low lasts low divider times two to the exponent, plus three.
// - Master clock high lasts high divider times two to the exponent, plus three.
// - Clock waveform writes are ignored while write protection is enabled.
// - Data held hold-plus-three cycles after falling edge; high speed changes at the edge.
// - Master transfer complete low during frame, set when idle after stop, cleared by write.
// - Slave transfer complete clears on start, sets on stop or foreign restart.
// - Receive ready sets on byte load, clears when software reads the receive register.
// - Master transmit ready clears on write, sets on shift, nack or master enable.
// - Slave transmit ready stays low from write until the byte is acknowledged or master enable is set.
// - Slave direction shows one for master read, zero for master write.
// - Slave access sets on address match and clears on nack or stop.
// - General call flag sets on general call and clears on status read.
// - Without stretching, reloading receive register while ready sets overrun.
// - Without stretching, transmit register not refilled in time sets underrun.
// - Master nack flag sets with transfer complete; clears on status read.
// - Slave read nack sets the flag; slave write acknowledges every byte.
// - Arbitration lost sets with transfer complete; clears on status read.
// - Slave stretches the clock and shows wait state when buffers are late.
// - End of slave access sets when slave access clears; clears on status read.
// - Buffer end flags set on counter zero, clear on a count register write.
// - Size field zero means no internal address, else that many bytes.
// - With stretch disable set, no slave stretching; errors are flagged instead.
`timescale 1ns/10ps

module twc_clkgen_status (
  // Clock, reset and freeze.
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // Register port.
  input  wire logic [31:0]            addr_i,
  input  wire logic [31:0]            wr_data_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rd_data_o,
  // Mode and configuration bits from the control and mode registers.
  input  wire logic                   master_mode_i,
  input  wire logic                   slave_mode_i,
  input  wire logic                   master_enable_i,
  input  wire logic                   high_speed_i,
  input  wire logic                   write_protect_enable_i,
  input  wire logic                   slave_stretch_disable_i,
  input  wire logic                   frame_active_i,
  input  wire logic [1:0]             internal_address_size_i,
  input  wire logic [1:0]             address_byte_sel_i,
  // Transfer events.
  input  wire twc_pkg::twc_event_type events_i,
  // Serial clock line, open drain, and sampled data line.
  input  wire logic                   serial_clock_line_i,
  output logic                        serial_clock_line_o,
  output logic                        serial_clock_line_oe_n_o,
  input  wire logic                   serial_data_line_i,
  // Shifter timing and internal address supply.
  output logic                        sda_update_o,
  output logic                        clock_fall_o,
  output logic [7:0]                  internal_address_byte_o,
  output logic [1:0]                  internal_address_count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic        status_sel;
  logic        cwgr_sel;
  logic        target_internal_address_sel;
  logic        status_clear;
  logic [31:0] status_vec;
  logic [31:0] clock_waveform_reg;
  logic [23:0] internal_address_reg;

  assign status_sel   = addr_i == twc_pkg::ADDR_TRANSFER_STATUS;
  assign cwgr_sel     = addr_i == twc_pkg::ADDR_CLOCK_WAVEFORM;
  assign target_internal_address_sel     = addr_i == twc_pkg::ADDR_INTERNAL_ADDRESS;
  assign status_clear = ce_i && rd_i && status_sel;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      internal_address_reg <= twc_pkg::RESET_INTERNAL_ADDRESS;
    end else if (ce_i && wr_i && target_internal_address_sel) begin
      internal_address_reg <= wr_data_i[23:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clock_waveform_reg <= twc_pkg::RESET_CLOCK_WAVEFORM;
    end else if (ce_i && wr_i && cwgr_sel && !write_protect_enable_i) begin
      clock_waveform_reg <= wr_data_i & twc_pkg::CW_WRITE_MASK;
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads give zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_data_o <= 32'h00000000;
    end else if (ce_i) begin
      if (rd_i && status_sel) begin
        rd_data_o <= status_vec;
      end else if (rd_i && cwgr_sel) begin
        rd_data_o <= clock_waveform_reg;
      end else if (rd_i && target_internal_address_sel) begin
        rd_data_o <= {8'h00, internal_address_reg};
      end else begin
        rd_data_o <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal address bytes, most significant byte first.

  logic [1:0]  target_internal_address_shift;
  logic [23:0] target_internal_address_shifted;

  assign target_internal_address_shift   = 2'(internal_address_size_i - 2'h1 - address_byte_sel_i);
  assign target_internal_address_shifted = internal_address_reg >> {target_internal_address_shift, 3'b000};

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      internal_address_byte_o  <= 8'h00;
      internal_address_count_o <= 2'h0;
    end else if (ce_i) begin
      internal_address_count_o <= internal_address_size_i;
      if (internal_address_size_i == 2'h0 ||
          address_byte_sel_i >= internal_address_size_i) begin
        internal_address_byte_o <= 8'h00;
      end else begin
        internal_address_byte_o <= target_internal_address_shifted[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock waveform.

  logic [7:0]  low_div;
  logic [7:0]  high_div;
  logic [2:0]  div_exp;
  logic [5:0]  hold_field;
  logic [15:0] low_period;
  logic [15:0] high_period;
  logic [15:0] count_reg;
  logic        clock_fall;
  twc_pkg::twc_clk_state_type state_reg;

  assign low_div     = clock_waveform_reg[twc_pkg::CW_LOW_POS +: 8];
  assign high_div    = clock_waveform_reg[twc_pkg::CW_HIGH_POS +: 8];
  assign div_exp     = clock_waveform_reg[twc_pkg::CW_EXP_POS +: 3];
  assign hold_field  = clock_waveform_reg[twc_pkg::CW_HOLD_POS +: 6];
  assign low_period  = ({8'h00, low_div} << div_exp) + twc_pkg::PERIOD_OFFSET;
  assign high_period = ({8'h00, high_div} << div_exp) + twc_pkg::PERIOD_OFFSET;
  assign clock_fall  = ce_i && master_mode_i && frame_active_i &&
                       (state_reg == twc_pkg::CG_IDLE ||
                        (state_reg == twc_pkg::CG_HIGH && count_reg == 16'h0000 &&
                         serial_clock_line_i));

  // A high phase only counts while the line is really high, so a slave that
  // stretches the clock lengthens the high phase instead of shortening it.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= twc_pkg::CG_IDLE;
      count_reg <= 16'h0000;
    end else if (ce_i) begin
      unique case (state_reg)
        twc_pkg::CG_IDLE: begin
          if (clock_fall) begin
            state_reg <= twc_pkg::CG_LOW;
            count_reg <= low_period - 16'h0001;
          end
        end
        twc_pkg::CG_LOW: begin
          if (count_reg != 16'h0000) begin
            count_reg <= count_reg - 16'h0001;
          end else begin
            state_reg <= twc_pkg::CG_HIGH;
            count_reg <= high_period - 16'h0001;
          end
        end
        twc_pkg::CG_HIGH: begin
          if (count_reg != 16'h0000) begin
            if (serial_clock_line_i) begin
              count_reg <= count_reg - 16'h0001;
            end
          end else if (clock_fall) begin
            state_reg <= twc_pkg::CG_LOW;
            count_reg <= low_period - 16'h0001;
          end else if (!frame_active_i || !master_mode_i) begin
            state_reg <= twc_pkg::CG_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data hold timing after each falling clock edge.

  logic [6:0] hold_count_reg;
  logic       hold_busy_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hold_count_reg <= 7'h00;
      hold_busy_reg  <= 1'b0;
      sda_update_o   <= 1'b0;
      clock_fall_o   <= 1'b0;
    end else if (ce_i) begin
      clock_fall_o <= clock_fall;
      if (high_speed_i) begin
        hold_busy_reg <= 1'b0;
        sda_update_o  <= clock_fall;
      end else if (clock_fall) begin
        hold_count_reg <= {1'b0, hold_field} + twc_pkg::HOLD_OFFSET - 7'h02;
        hold_busy_reg  <= 1'b1;
        sda_update_o   <= 1'b0;
      end else if (hold_busy_reg && hold_count_reg == 7'h00) begin
        hold_busy_reg <= 1'b0;
        sda_update_o  <= 1'b1;
      end else begin
        hold_count_reg <= hold_count_reg - {6'h00, hold_busy_reg};
        sda_update_o   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer status flags.

  logic transfer_complete_reg;
  logic receive_ready_reg;
  logic transmit_ready_reg;
  logic slave_direction_reg;
  logic slave_access_reg;
  logic general_call_seen_reg;
  logic overrun_flag_reg;
  logic underrun_flag_reg;
  logic nack_reg;
  logic arbitration_lost_reg;
  logic clock_wait_state_reg;
  logic end_of_slave_access_reg;
  logic end_of_receive_buffer_reg;
  logic end_of_transmit_buffer_reg;
  logic slave_access_next;
  logic wait_needed;
  logic late_tx;
  logic late_rx;

  assign late_tx = slave_access_reg && slave_direction_reg && events_i.next_char_due &&
                   transmit_ready_reg && !nack_reg;
  assign late_rx = slave_access_reg && !slave_direction_reg && events_i.next_char_due &&
                   receive_ready_reg;
  assign wait_needed = slave_mode_i && !slave_stretch_disable_i && (late_tx || late_rx);
  assign slave_access_next = (slave_mode_i && events_i.addr_match) ||
                             (slave_access_reg && !events_i.nack_seen &&
                              !events_i.stop_seen);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      transfer_complete_reg <= twc_pkg::RESET_TRANSFER_COMPLETE;
      transmit_ready_reg    <= twc_pkg::RESET_TRANSMIT_READY;
    end else if (ce_i) begin
      if (master_mode_i) begin
        if ((events_i.shifter_empty && events_i.stop_sent) || events_i.nack_seen ||
            events_i.arb_lost) begin
          transfer_complete_reg <= 1'b1;
        end else if (events_i.thr_write || frame_active_i) begin
          transfer_complete_reg <= 1'b0;
        end
        if (events_i.byte_to_shifter || events_i.nack_seen || master_enable_i) begin
          transmit_ready_reg <= 1'b1;
        end else if (events_i.thr_write) begin
          transmit_ready_reg <= 1'b0;
        end
      end else begin
        if (events_i.stop_seen || events_i.restart_other_addr) begin
          transfer_complete_reg <= 1'b1;
        end else if (events_i.start_seen) begin
          transfer_complete_reg <= 1'b0;
        end
        if (events_i.tx_byte_acked) begin
          transmit_ready_reg <= 1'b1;
        end else if (events_i.thr_write) begin
          transmit_ready_reg <= 1'b0;
        end else if (master_enable_i) begin
          transmit_ready_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      receive_ready_reg <= 1'b0;
    end else if (ce_i) begin
      receive_ready_reg <= events_i.rx_byte_loaded ||
                           (receive_ready_reg && !events_i.rhr_read);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      slave_access_reg        <= 1'b0;
      slave_direction_reg     <= 1'b0;
      end_of_slave_access_reg <= 1'b0;
      clock_wait_state_reg    <= 1'b0;
    end else if (ce_i) begin
      slave_access_reg <= slave_access_next;
      if (slave_mode_i && events_i.addr_match) begin
        slave_direction_reg <= events_i.addr_read_bit;
      end
      end_of_slave_access_reg <= (slave_access_reg && !slave_access_next) ||
                                 (end_of_slave_access_reg && !status_clear);
      clock_wait_state_reg <= wait_needed;
    end
  end

  // Every clear-on-read flag lets a set in the reading cycle win over the clear.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      general_call_seen_reg <= 1'b0;
      overrun_flag_reg      <= 1'b0;
      underrun_flag_reg     <= 1'b0;
      nack_reg              <= 1'b0;
      arbitration_lost_reg  <= 1'b0;
    end else if (ce_i) begin
      general_call_seen_reg <= (slave_mode_i && events_i.general_call) ||
                               (general_call_seen_reg && !status_clear);
      overrun_flag_reg <= (slave_stretch_disable_i && events_i.rx_byte_loaded &&
                           receive_ready_reg) ||
                          (overrun_flag_reg && !status_clear);
      underrun_flag_reg <= (slave_stretch_disable_i && slave_mode_i && late_tx) ||
                           (underrun_flag_reg && !status_clear);
      nack_reg <= (events_i.nack_seen && (master_mode_i || slave_direction_reg)) ||
                  (nack_reg && !status_clear);
      arbitration_lost_reg <= (master_mode_i && events_i.arb_lost) ||
                              (arbitration_lost_reg && !status_clear);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      end_of_receive_buffer_reg  <= 1'b0;
      end_of_transmit_buffer_reg <= 1'b0;
    end else if (ce_i) begin
      end_of_receive_buffer_reg <= events_i.rx_count_zero ||
                                   (end_of_receive_buffer_reg &&
                                    !events_i.rx_count_write);
      end_of_transmit_buffer_reg <= events_i.tx_count_zero ||
                                    (end_of_transmit_buffer_reg &&
                                     !events_i.tx_count_write);
    end
  end

  always_comb begin
    status_vec = 32'h00000000;
    status_vec[twc_pkg::SR_TRANSFER_COMPLETE] = transfer_complete_reg;
    status_vec[twc_pkg::SR_RECEIVE_READY]     = receive_ready_reg;
    status_vec[twc_pkg::SR_TRANSMIT_READY]    = transmit_ready_reg;
    status_vec[twc_pkg::SR_SLAVE_DIRECTION]   = slave_direction_reg;
    status_vec[twc_pkg::SR_SLAVE_ACCESS]      = slave_access_reg;
    status_vec[twc_pkg::SR_GENERAL_CALL]      = general_call_seen_reg;
    status_vec[twc_pkg::SR_OVERRUN]           = overrun_flag_reg;
    status_vec[twc_pkg::SR_UNDERRUN]          = underrun_flag_reg;
    status_vec[twc_pkg::SR_NACK]              = nack_reg;
    status_vec[twc_pkg::SR_ARBITRATION_LOST]  = arbitration_lost_reg;
    status_vec[twc_pkg::SR_CLOCK_WAIT]        = clock_wait_state_reg;
    status_vec[twc_pkg::SR_END_SLAVE_ACCESS]  = end_of_slave_access_reg;
    status_vec[twc_pkg::SR_END_RX_BUFFER]     = end_of_receive_buffer_reg;
    status_vec[twc_pkg::SR_END_TX_BUFFER]     = end_of_transmit_buffer_reg;
    status_vec[twc_pkg::SR_CLOCK_LINE]        = serial_clock_line_i;
    status_vec[twc_pkg::SR_DATA_LINE]         = serial_data_line_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock line: pulled low for the master low phase or a slave stretch.

  assign serial_clock_line_o      = 1'b0;
  assign serial_clock_line_oe_n_o = !(state_reg == twc_pkg::CG_LOW || clock_wait_state_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_status_read;
    ce_i && rd_i && status_sel;
  endsequence

  sequence s_low_done;
    ce_i && state_reg == twc_pkg::CG_LOW && count_reg == 16'h0000;
  endsequence

  a_low_load: assert property (@(posedge clock_i) disable iff (rst_i)
    clock_fall |=> state_reg == twc_pkg::CG_LOW && count_reg == $past(low_period) - 16'h0001)
    else $error("low phase loaded with wrong count");

  a_high_load: assert property (@(posedge clock_i) disable iff (rst_i)
    s_low_done |=> state_reg == twc_pkg::CG_HIGH && !serial_clock_line_oe_n_o == clock_wait_state_reg
      && count_reg == $past(high_period) - 16'h0001)
    else $error("high phase loaded with wrong count");

  a_cwgr_protect: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && wr_i && cwgr_sel && write_protect_enable_i |=> $stable(clock_waveform_reg))
    else $error("protected clock waveform register changed");

  a_hs_data_edge: assert property (@(posedge clock_i) disable iff (rst_i)
    high_speed_i && clock_fall |=> sda_update_o)
    else $error("high speed data did not change at falling edge");

  a_rx_ready_set: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && events_i.rx_byte_loaded |=> receive_ready_reg)
    else $error("receive ready not set on byte load");

  a_transmit_ready_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && master_mode_i && events_i.thr_write && !events_i.byte_to_shifter &&
    !events_i.nack_seen && !master_enable_i |=> !transmit_ready_reg)
    else $error("transmit ready not cleared by holding register write");

  a_end_access: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(slave_access_reg) |-> end_of_slave_access_reg)
    else $error("end of slave access not set");

  a_status_return: assert property (@(posedge clock_i) disable iff (rst_i)
    s_status_read |=> rd_data_o == $past(status_vec))
    else $error("status read returned wrong value");

  a_clear_keep: assert property (@(posedge clock_i) disable iff (rst_i)
    s_status_read ##0 (slave_mode_i && events_i.general_call) |=> general_call_seen_reg)
    else $error("general call lost in clearing cycle");

  a_stretch_wait: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && wait_needed |=> clock_wait_state_reg && !serial_clock_line_oe_n_o)
    else $error("slave did not stretch the clock");

endmodule

// >>> verif/twc_line_model.sv
/*
 * Far side of the two-wire bus: a pulled-up clock line and a data line.
 * Assumes the block pulls the clock line low through an active-low enable.
 */
`timescale 1ns/10ps

module twc_line_model (
  // Line drive from the block.
  input  wire logic clock_oe_n_i,
  // Line levels seen by the block.
  output logic      clock_line_o,
  output logic      data_line_o
);
  // The pull-up wins as soon as the block lets go, so the high count starts at once.
  assign clock_line_o = clock_oe_n_i ? 1'b1 : 1'b0;
  assign data_line_o  = 1'b1;
endmodule

// >>> verif/testbench.sv
/*
 * Self-checking bench for the clock generator and transfer status block.
 * Assumes the pulled-up line model on the clock and data lines.
 */
`timescale 1ns/10ps

module testbench;
  logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, mm = 0, fa = 0, wp = 0, sd = 0, hs = 0;
  logic [31:0] addr_i = '0, wd = '0, rd_data_o, v;
  logic [1:0] sz = '0;
  logic [19:0] ev_r = '0;
  logic oe_n, scl, sda, upd, cf;
  logic [1:0] ia_n;
  logic [7:0] ia_b;
  int failures = 0, tests_run = 0, cyc = 0, n;
  always #25 clock_i = ~clock_i;
  twc_line_model twc_line_model_i (.clock_oe_n_i(oe_n), .clock_line_o(scl), .data_line_o(sda));
  twc_clkgen_status twc_clkgen_status_i (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .addr_i(addr_i), .wr_data_i(wd), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .master_mode_i(mm), .slave_mode_i(~mm), .master_enable_i(1'b0), .high_speed_i(hs),
    .write_protect_enable_i(wp), .slave_stretch_disable_i(sd), .frame_active_i(fa),
    .internal_address_size_i(sz), .address_byte_sel_i(2'h0),
    .events_i(twc_pkg::twc_event_type'(ev_r)), .serial_clock_line_i(scl),
    .serial_clock_line_o(), .serial_clock_line_oe_n_o(oe_n), .serial_data_line_i(sda),
    .sda_update_o(upd), .clock_fall_o(cf), .internal_address_byte_o(ia_b),
    .internal_address_count_o(ia_n));
  //////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i) {wr_i, addr_i, wd} <= {1'b1, a, d};
    @(posedge clock_i) wr_i <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    @(posedge clock_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge clock_i) rd_i <= 1'b0;
    @(negedge clock_i) chk(nm, e, rd_data_o & 32'h3fff);
  endtask
  // Event bundle bits: 19 holding write, 18 receive read, 16 byte loaded, 8 nack,
  // 7 general call, 6 arbitration lost.
  task ev(input int b);
    @(posedge clock_i) ev_r <= 20'h1 << b;
    @(posedge clock_i) ev_r <= '0;
  endtask
  // A status read with an event pulse in the same cycle.
  task rd_ev(input logic [19:0] e);
    @(posedge clock_i) {rd_i, addr_i, ev_r} <= {1'b1, twc_pkg::ADDR_TRANSFER_STATUS, e};
    @(posedge clock_i) {rd_i, ev_r} <= '0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task s_flags;
    mm <= 1'b1;
    rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h1, "st_reset");
    ev(19); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h0, "st_thr");
    ev(8); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h105, "st_nack");
    rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h5, "st_nack_clr");
    // General call and slave access are slave mode events.
    @(posedge clock_i) mm <= 1'b0;
    ev(7); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h25, "st_gc");
    rd_ev(20'h80); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h25, "st_gc_keep");
    ev(10); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h15, "st_acc");
    ev(12); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h805, "st_eos");
    @(posedge clock_i) sd <= 1'b1;
    ev(16); ev(16); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h47, "st_ovr");
    ev(18); rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h5, "st_rx_clr");
    @(posedge clock_i) mm <= 1'b1;
    rd_ev(20'h40);
    rd(twc_pkg::ADDR_TRANSFER_STATUS, 32'h205, "st_arb");
  endtask
  task s_regs;
    wr(twc_pkg::ADDR_CLOCK_WAVEFORM, 32'hc2010102);
    rd(twc_pkg::ADDR_CLOCK_WAVEFORM, 32'h0102, "cw_lo");
    @(posedge clock_i) wp <= 1'b1;
    wr(twc_pkg::ADDR_CLOCK_WAVEFORM, 32'h5);
    @(posedge clock_i) {rd_i, addr_i} <= {1'b1, twc_pkg::ADDR_CLOCK_WAVEFORM};
    @(posedge clock_i) rd_i <= 1'b0;
    @(negedge clock_i) chk("cw_wp", 32'h02010102, rd_data_o);
    wr(twc_pkg::ADDR_INTERNAL_ADDRESS, 32'h00123456);
    sz <= 2'h3;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i) chk("ia_3", 32'h312, {ia_n, ia_b});
    sz <= 2'h0;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i) chk("ia_0", 32'h0, {ia_n, ia_b});
  endtask
  task s_clock;
    @(posedge clock_i) fa <= 1'b1;
    n = 0;
    while (oe_n !== 1'b0 && n < 50) @(negedge clock_i) n++;
    v = '0;
    for (n = 0; oe_n === 1'b0 && n < 50; n++) begin
      // The shifter acts on the update pulse at the following edge.
      if (upd === 1'b1) v = n + 1;
      @(negedge clock_i);
    end
    chk("hold", 32'h5, v);
    chk("low", 32'h7, n);
    for (n = 0; oe_n === 1'b1 && n < 50; n++) @(negedge clock_i);
    chk("high", 32'h5, n);
    // In high-speed mode the update comes in the first low cycle.
    @(posedge clock_i) hs <= 1'b1;
    for (n = 0; oe_n === 1'b0 && n < 50; n++) @(negedge clock_i);
    for (n = 0; oe_n === 1'b1 && n < 50; n++) @(negedge clock_i);
    chk("hs_upd", 32'h1, upd);
    chk("fall_out", 32'h1, cf);
    @(posedge clock_i) {fa, hs} <= '0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    s_flags();
    s_regs();
    s_clock();
    complete_run();
  end
endmodule
